// file: design/ecd_pkg.sv
/*
  Shared constants and the state type of the endpoint command decoder.
  Assumes a 20 MHz system clock; the decoder and the testbench import this package.
*/
`default_nettype none

package ecd_pkg;

  // ----------------------------------------------------------------------
  // Clock and completion times
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;   // System clock period.
  localparam int CMD_DONE_NS   = 100;  // Busy time of an ordinary command.
  localparam int LONG_DONE_NS  = 300;  // Busy time of slow commands on the 8-bit bus.
  // Least times, so rounded up to whole cycles.
  localparam logic [3:0] SHORT_CYC = 4'((CMD_DONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] LONG_CYC  = 4'((LONG_DONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------------
  // Command groups (upper nibble) and whole command codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] GRP_STALL   = 4'h4;  // Set stall, no data.
  localparam logic [3:0] GRP_STATUS  = 4'h5;  // Read status, clears it.
  localparam logic [3:0] GRP_VALID   = 4'h6;  // Validate an IN buffer.
  localparam logic [3:0] GRP_CLRBUF  = 4'h7;  // Release an OUT buffer.
  localparam logic [3:0] GRP_UNSTALL = 4'h8;  // Remove stall, no data.
  localparam logic [3:0] GRP_ERR     = 4'hA;  // Read error code.
  localparam logic [3:0] GRP_CHECK   = 4'hD;  // Read status image, no clear.

  localparam logic [7:0] CMD_UNLOCK    = 8'hB0;
  localparam logic [7:0] CMD_SCR_WR    = 8'hB2;
  localparam logic [7:0] CMD_SCR_RD    = 8'hB3;
  localparam logic [7:0] CMD_FRAME     = 8'hB4;
  localparam logic [7:0] CMD_INTR      = 8'hC0;
  localparam logic [7:0] CMD_SETUP_ACK = 8'hF4;

  localparam logic [3:0] EP_CTRL_OUT = 4'h0;  // Endpoint slot of control OUT.
  localparam logic [3:0] EP_CTRL_IN  = 4'h1;  // Endpoint slot of control IN.

  localparam logic [15:0] UNLOCK_KEY = 16'hAA37;  // Value that unlocks writes.

  // Data phase lengths in bytes and index steps.
  localparam logic [2:0] LEN_NONE = 3'h0;
  localparam logic [2:0] LEN_BYTE = 3'h1;
  localparam logic [2:0] LEN_WORD = 3'h2;
  localparam logic [2:0] LEN_QUAD = 3'h4;
  localparam logic [2:0] STEP_8   = 3'h1;
  localparam logic [2:0] STEP_16  = 3'h2;

  // ----------------------------------------------------------------------
  // Decoder state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  cmd;        // Last command code taken.
    logic [2:0]  len;        // Bytes in the data phase of that command.
    logic        rd_ok;      // Command has a read data phase.
    logic        wr_ok;      // Command has a write data phase.
    logic [2:0]  idx;        // Next byte of the data phase.
    logic [15:0] wbuf;       // Collected write bytes.
    logic [15:0] scratch;    // Scratch register.
    logic        unlocked;   // Register writes allowed.
    logic [3:0]  busy_cnt;   // Cycles left until the command completes.
    logic [15:0] dout;       // Read data on the host bus.
    logic        stall_set;  // Pulses towards the endpoint logic.
    logic        stall_clr;
    logic        validate;
    logic        clr_buf;
    logic        setup_ack;
    logic        st_clr;
    logic        unlock_p;
    logic [3:0]  ep;         // Endpoint slot of the last command.
    logic        wr_prev;    // Filtered write strobe, one cycle ago.
    logic        rd_prev;    // Filtered read strobe, one cycle ago.
  } ecd_state_t;

endpackage

`default_nettype wire

// file: design/ecd_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes asynchronous inputs; the output changes only when stages two and
  three agree, so a single-cycle glitch is never passed on.
*/
`timescale 1ns/1ps
`default_nettype none

module ecd_sync #(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '1
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;   // First stage, read only by the second.
    logic [W-1:0] s2;   // Second stage.
    logic [W-1:0] s3;   // Third stage.
    logic [W-1:0] lvl;  // Filtered level.
  } ecd_sync_st_t;

  ecd_sync_st_t s_r;   // Registered state.
  ecd_sync_st_t s_nxt; // Next state.

  if (W < 1) begin : g_chk
    $error("ecd_sync needs at least one bit");
  end

  // Shift the stages and take over each bit once the last two agree.
  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    for (int i = 0; i < W; i++) begin
      if (s_r.s2[i] == s_r.s3[i]) begin
        s_nxt.lvl[i] = s_r.s3[i];
      end
    end
  end

  // Register the state; reset holds the idle level.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '{s1: RST, s2: RST, s3: RST, lvl: RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.lvl;

endmodule

`default_nettype wire

// file: design/ecd_decoder.sv
/*
  Endpoint command decoder of a full-speed peripheral controller host port.
  Assumes an external microcontroller on a parallel bus with active-low chip
  select, read and write strobes, address bit a0 and 16 data lines; the
  endpoint logic, frame counter and interrupt register sit outside and are
  seen through plain ports on the same clock.

*/
`timescale 1ns/1ps
`default_nettype none

module ecd_decoder #(
  parameter int FRAME_W = 11  // Width of the frame number.
) (
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                host_cs_b,
  input  wire logic                host_rd_b,
  input  wire logic                host_wr_b,
  input  wire logic                host_a0,
  input  wire logic [15:0]         host_d_in,
  output logic      [15:0]         host_d_out,
  output logic                     host_d_oe,
  input  wire logic                bus16,
  input  wire logic [127:0]        ep_status,
  input  wire logic [127:0]        ep_err_code,
  input  wire logic [FRAME_W-1:0]  frame_num,
  input  wire logic [31:0]         intr_reg,
  input  wire logic                lock_req,
  output logic                     busy,
  output logic                     stall_set,
  output logic                     stall_clr,
  output logic                     buf_validate,
  output logic                     buf_clear,
  output logic                     setup_ack,
  output logic                     status_clear,
  output logic                     unlock,
  output logic                     regs_unlocked,
  output logic      [3:0]          ep_sel,
  output logic      [15:0]         scratch
);

  import ecd_pkg::*;

  if (FRAME_W < 1 || FRAME_W > 16) begin : g_chk
    $error("FRAME_W must be 1 to 16");
  end

  // ----------------------------------------------------------------------
  // Strobe synchronisation
  // ----------------------------------------------------------------------
  logic [2:0]  strb_s;   // Filtered {cs, rd, wr}, active low.
  logic        cs_s;     // Filtered chip select.
  logic        rd_s;     // Filtered read strobe.
  logic        wr_s;     // Filtered write strobe.

  ecd_sync #(
    .W   (3),
    .RST (3'h7)
  ) u_sync (
    .clock (clock),
    .rst_b (rst_b),
    .d     ({host_cs_b, host_rd_b, host_wr_b}),
    .q     (strb_s)
  );
  assign cs_s = strb_s[2];
  assign rd_s = strb_s[1];
  assign wr_s = strb_s[0];
  ecd_state_t s_r;    // Registered state.
  ecd_state_t s_nxt;  // Next state.
  logic        wr_fall;    // Start of a selected write access.
  logic        rd_fall;    // Start of a selected read access.
  logic        cmd_take;   // A command code is taken this cycle.
  logic [7:0]  code;       // Command code on the low data byte.
  logic [31:0] rd_src;     // Register selected by the current read command.
  logic [7:0]  ep_st_byte; // Status byte of the addressed endpoint.
  assign wr_fall  = s_r.wr_prev & ~wr_s & ~cs_s;
  assign rd_fall  = s_r.rd_prev & ~rd_s & ~cs_s;
  assign cmd_take = wr_fall & host_a0;
  assign code     = host_d_in[7:0];
  assign ep_st_byte = ep_status[{s_r.ep, 3'h0} +: 8];

  // ----------------------------------------------------------------------
  // Read source selection
  // ----------------------------------------------------------------------
  // Picks the register behind the current read command, zero extended.
  always_comb begin
    rd_src = 32'h0000_0000;
    case (s_r.cmd[7:4])
      GRP_STATUS, GRP_CHECK: begin
        rd_src[7:0] = ep_st_byte;
      end
      GRP_ERR: begin
        rd_src[7:0] = ep_err_code[{s_r.ep, 3'h0} +: 8];
      end
      default: begin
        if (s_r.cmd == CMD_SCR_RD) begin
          rd_src[15:0] = s_r.scratch;
        end else if (s_r.cmd == CMD_FRAME) begin
          rd_src[FRAME_W-1:0] = frame_num;
        end else if (s_r.cmd == CMD_INTR) begin
          rd_src = intr_reg;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Command and data phase decoding
  // ----------------------------------------------------------------------
  // Decodes command codes, collects write bytes and serves read bytes.
  always_comb begin
    logic [2:0]  hidx;  // Index of the upper byte of a word access.
    logic [2:0]  nidx;  // Index after this write access.
    logic [15:0] wval;  // Write value once complete.
    logic [3:0]  slow;  // Busy time of a slow command.
    hidx = 3'(s_r.idx + STEP_8);
    nidx = s_r.idx;
    wval = s_r.wbuf;
    slow = bus16 ? SHORT_CYC : LONG_CYC;
    s_nxt = s_r;
    s_nxt.stall_set = 1'b0;
    s_nxt.stall_clr = 1'b0;
    s_nxt.validate  = 1'b0;
    s_nxt.clr_buf   = 1'b0;
    s_nxt.setup_ack = 1'b0;
    s_nxt.st_clr    = 1'b0;
    s_nxt.unlock_p  = 1'b0;
    s_nxt.wr_prev   = wr_s;
    s_nxt.rd_prev   = rd_s;
    if (s_r.busy_cnt != 4'h0) begin
      s_nxt.busy_cnt = 4'(s_r.busy_cnt - 4'h1);
    end
    // A relock request loses against an unlock in the same cycle.
    if (lock_req) begin
      s_nxt.unlocked = 1'b0;
    end
    if (cmd_take) begin
      // A command with no data phase acts at once.
      s_nxt.cmd   = code;
      s_nxt.ep    = code[3:0];
      s_nxt.idx   = 3'h0;
      s_nxt.len   = LEN_NONE;
      s_nxt.rd_ok = 1'b0;
      s_nxt.wr_ok = 1'b0;
      case (code[7:4])
        GRP_STALL: begin
          s_nxt.stall_set = 1'b1;
          s_nxt.busy_cnt  = SHORT_CYC;
        end
        GRP_UNSTALL: begin
          s_nxt.stall_clr = 1'b1;
          s_nxt.busy_cnt  = SHORT_CYC;
        end
        GRP_STATUS, GRP_CHECK, GRP_ERR: begin
          s_nxt.rd_ok = 1'b1;
          s_nxt.len   = LEN_BYTE;
        end
        GRP_VALID: begin
          // The control OUT slot is illegal here and left alone.
          if (code[3:0] != EP_CTRL_OUT) begin
            s_nxt.validate = 1'b1;
            s_nxt.busy_cnt = slow;
          end
        end
        GRP_CLRBUF: begin
          // The control IN slot is illegal here and left alone.
          if (code[3:0] != EP_CTRL_IN) begin
            s_nxt.clr_buf  = 1'b1;
            s_nxt.busy_cnt = slow;
          end
        end
        default: begin
          if (code == CMD_UNLOCK || code == CMD_SCR_WR) begin
            s_nxt.wr_ok = 1'b1;
            s_nxt.len   = LEN_WORD;
          end else if (code == CMD_SCR_RD || code == CMD_FRAME) begin
            s_nxt.rd_ok = 1'b1;
            s_nxt.len   = LEN_WORD;
          end else if (code == CMD_INTR) begin
            s_nxt.rd_ok = 1'b1;
            s_nxt.len   = LEN_QUAD;
          end else if (code == CMD_SETUP_ACK) begin
            s_nxt.setup_ack = 1'b1;
            s_nxt.busy_cnt  = slow;
          end
          // Any other code, 00h and 11h among them, does nothing.
        end
      endcase
    end else if (wr_fall && s_r.wr_ok && s_r.idx < s_r.len) begin
      // Write data, least significant byte first.
      if (bus16) begin
        wval = host_d_in;
        nidx = 3'(s_r.idx + STEP_16);
      end else begin
        if (s_r.idx == 3'h0) begin
          wval[7:0] = host_d_in[7:0];
        end else begin
          wval[15:8] = host_d_in[7:0];
        end
        nidx = 3'(s_r.idx + STEP_8);
      end
      s_nxt.wbuf = wval;
      s_nxt.idx  = nidx;
      if (nidx >= s_r.len) begin
        if (s_r.cmd == CMD_SCR_WR) begin
          s_nxt.scratch = wval;
        end else if (wval == UNLOCK_KEY) begin
          s_nxt.unlocked = 1'b1;
          s_nxt.unlock_p = 1'b1;
        end
      end
    end else if (rd_fall && !host_a0 && s_r.rd_ok) begin
      // Read data; bytes past the register's end read as zero.
      s_nxt.dout = 16'h0000;
      if (s_r.idx < s_r.len) begin
        s_nxt.dout[7:0] = rd_src[{s_r.idx[1:0], 3'h0} +: 8];
      end
      if (bus16) begin
        if (hidx < s_r.len) begin
          s_nxt.dout[15:8] = rd_src[{hidx[1:0], 3'h0} +: 8];
        end
        s_nxt.idx = 3'(s_r.idx + STEP_16);
      end else begin
        s_nxt.idx = 3'(s_r.idx + STEP_8);
      end
      // Only the clearing status read tells the endpoint logic.
      if (s_r.cmd[7:4] == GRP_STATUS && s_r.idx == 3'h0) begin
        s_nxt.st_clr = 1'b1;
      end
    end
  end
  // Register the state.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_r         <= '0;
      s_r.wr_prev <= 1'b1;
      s_r.rd_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign host_d_out    = s_r.dout;
  assign host_d_oe     = s_r.rd_ok & ~rd_s & ~cs_s;
  assign busy          = (s_r.busy_cnt != 4'h0);
  assign stall_set     = s_r.stall_set;
  assign stall_clr     = s_r.stall_clr;
  assign buf_validate  = s_r.validate;
  assign buf_clear     = s_r.clr_buf;
  assign setup_ack     = s_r.setup_ack;
  assign status_clear  = s_r.st_clr;
  assign unlock        = s_r.unlock_p;
  assign regs_unlocked = s_r.unlocked;
  assign ep_sel        = s_r.ep;
  assign scratch       = s_r.scratch;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_slow_cmd;
    cmd_take && !bus16 && code[7:4] == GRP_VALID && code[3:0] != EP_CTRL_OUT;
  endsequence
  sequence s_long_busy;
    busy [*6] ##1 !busy;
  endsequence
  property p_stall;
    cmd_take && code[7:4] == GRP_STALL |=> stall_set && ep_sel == $past(code[3:0]);
  endproperty
  a_stall: assert property (p_stall) else $error("stall pulse missing");
  property p_unstall;
    cmd_take && code[7:4] == GRP_UNSTALL |=> stall_clr && !stall_set;
  endproperty
  a_unstall: assert property (p_unstall) else $error("unstall pulse missing");
  property p_status;
    rd_fall && !host_a0 && s_r.rd_ok && s_r.cmd[7:4] == GRP_STATUS && s_r.idx == 3'h0
      |=> status_clear && host_d_out[7:0] == $past(ep_st_byte);
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");
  property p_check;
    s_r.cmd[7:4] == GRP_CHECK && !cmd_take |=> !status_clear;
  endproperty
  a_check: assert property (p_check) else $error("status image read cleared status");
  property p_validate;
    s_slow_cmd |=> buf_validate ##0 s_long_busy;
  endproperty
  a_validate: assert property (p_validate) else $error("validate or busy time wrong");
  property p_clear;
    cmd_take && code[7:4] == GRP_CLRBUF && code[3:0] != EP_CTRL_IN |=> buf_clear ##0 busy;
  endproperty
  a_clear: assert property (p_clear) else $error("buffer clear missing");
  property p_setup;
    cmd_take && code == CMD_SETUP_ACK |=> setup_ack && !s_r.rd_ok && !s_r.wr_ok;
  endproperty
  a_setup: assert property (p_setup) else $error("setup acknowledge missing");
  property p_unlock;
    unlock |-> regs_unlocked && s_r.cmd == CMD_UNLOCK && s_r.wbuf == UNLOCK_KEY;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock without key");
  property p_illegal;
    cmd_take && (code == 8'h00 || code == 8'h11 || code == 8'h60 || code == 8'h71)
      |=> !(stall_set || stall_clr || buf_validate || buf_clear || setup_ack);
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal code acted");
  property p_word;
    rd_fall && !host_a0 && s_r.rd_ok && bus16 && !cmd_take
      |=> s_r.idx == 3'($past(s_r.idx) + STEP_16);
  endproperty
  a_word: assert property (p_word) else $error("word access step wrong");
endmodule

`default_nettype wire

// file: tb/ecd_host.sv
/*
  Host microcontroller model for the parallel command and data bus.
  Assumes one caller runs its tasks in turn, on the decoder's clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ecd_host (
  input  wire logic        clock,
  output logic             cs_b,
  output logic             rd_b,
  output logic             wr_b,
  output logic             a0,
  output logic [15:0]      dq,
  input  wire logic [15:0] d_in
);
  // The bus starts idle with both strobes high.
  initial begin
    cs_b = 1'b1;
    rd_b = 1'b1;
    wr_b = 1'b1;
    a0   = 1'b0;
    dq   = 16'h0000;
  end

  // Write access: a0 high sends a command code, a0 low sends data.
  // Strobe low six cycles and high six more, so slow commands can finish.
  task automatic wr(input logic a, input logic [15:0] v);
    @(posedge clock);
    a0   <= a;
    dq   <= v;
    cs_b <= 1'b0;
    wr_b <= 1'b0;
    repeat (6) @(posedge clock);
    cs_b <= 1'b1;
    wr_b <= 1'b1;
    dq   <= ~v;
    repeat (6) @(posedge clock);
  endtask

  // Read access: data is taken at the last edge before the strobe rises.
  task automatic rd(output logic [15:0] v);
    @(posedge clock);
    a0   <= 1'b0;
    cs_b <= 1'b0;
    rd_b <= 1'b0;
    repeat (8) @(posedge clock);
    v = d_in;
    cs_b <= 1'b1;
    rd_b <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
endmodule

`default_nettype wire

// file: tb/endpoint_command_decoder_tb.sv
/*
  Self-checking testbench of the endpoint command decoder.
  Assumes the host model in ecd_host.sv and the decoder's own assertions.
*/
`timescale 1ns/1ps
`default_nettype none

module endpoint_command_decoder_tb;
  import ecd_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic         clock;
  logic         rst_b;
  logic         bus16;
  logic         lock_req;
  logic [127:0] ep_status;
  logic [127:0] ep_err_code;
  logic [10:0]  frame_num;
  logic [31:0]  intr_reg;
  wire          cs_b, rd_b, wr_b, a0, d_oe, busy, unl;
  wire  [15:0]  dq, d_out, scr;
  wire  [6:0]   pl;                // Pulse outputs, one bit each.
  wire  [3:0]   ep;
  int           fail_count;
  int           checks;
  int           oe_cnt;            // Cycles in which the decoder drives the bus.
  int           cnt [0:7];         // Pulse counts 0..6, busy cycles 7.

  ecd_host host (.clock(clock), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .a0(a0),
                 .dq(dq), .d_in(d_out));
  ecd_decoder #(.FRAME_W(11)) dut (.clock(clock), .rst_b(rst_b), .host_cs_b(cs_b),
    .host_rd_b(rd_b), .host_wr_b(wr_b), .host_a0(a0), .host_d_in(dq),
    .host_d_out(d_out), .host_d_oe(d_oe), .bus16(bus16), .ep_status(ep_status),
    .ep_err_code(ep_err_code), .frame_num(frame_num), .intr_reg(intr_reg),
    .lock_req(lock_req), .busy(busy), .stall_set(pl[0]), .stall_clr(pl[1]),
    .buf_validate(pl[2]), .buf_clear(pl[3]), .setup_ack(pl[4]),
    .status_clear(pl[5]), .unlock(pl[6]), .regs_unlocked(unl), .ep_sel(ep),
    .scratch(scr));

  // Free-running counters; scenarios compare differences, not absolutes.
  always @(posedge clock) begin
    if (busy === 1'b1) cnt[7]++;
    if (d_oe === 1'b1) oe_cnt++;
    for (int k = 0; k < 7; k++) if (pl[k] === 1'b1) cnt[k]++;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] stv(int k);
    return 8'(k * 17 + 8'h5A);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Command without data: pulse p (or none for -1), bl busy cycles, slot e.
  task automatic cmd(input logic [7:0] c, input int p, input int bl, input logic [3:0] e);
    int s [0:7];
    s = cnt;
    host.wr(1'b1, {8'h00, c});
    for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clock);
    for (int k = 0; k < 7; k++) chk(cnt[k] - s[k], 32'(k == p));
    chk(cnt[7] - s[7], bl);
    if (p >= 0) chk(ep, e);
  endtask

  // One-byte register read; only the low byte counts, the check drops the rest.
  task automatic rd1(input logic [7:0] c, input logic [7:0] exp, input int sc);
    int          s;
    int          so;
    logic [15:0] v;
    host.wr(1'b1, {8'h00, c});
    s  = cnt[5];
    so = oe_cnt;
    host.rd(v);
    chk(v[7:0], exp);
    chk(cnt[5] - s, sc);
    // The decoder drives for the eight cycles its filtered strobe stays low.
    chk(oe_cnt - so, 8);
  endtask

  task automatic rdw(input logic [15:0] exp);
    logic [15:0] v;
    host.rd(v);
    chk(v, exp);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_nodata();
    bus16 <= 1'b0;
    cmd(8'h40, 0, SHORT_CYC, 4'h0);
    cmd(8'h41, 0, SHORT_CYC, 4'h1);
    cmd(8'h4F, 0, SHORT_CYC, 4'hF);
    cmd(8'h80, 1, SHORT_CYC, 4'h0);
    cmd(8'h81, 1, SHORT_CYC, 4'h1);
    cmd(8'h8F, 1, SHORT_CYC, 4'hF);
    cmd(8'h61, 2, LONG_CYC, 4'h1);
    cmd(8'h6F, 2, LONG_CYC, 4'hF);
    cmd(8'h70, 3, LONG_CYC, 4'h0);
    cmd(8'h7F, 3, LONG_CYC, 4'hF);
    cmd(8'hF4, 4, LONG_CYC, 4'h4);
    bus16 <= 1'b1;
    cmd(8'h62, 2, SHORT_CYC, 4'h2);
    cmd(8'h72, 3, SHORT_CYC, 4'h2);
    cmd(8'hF4, 4, SHORT_CYC, 4'h4);
    cmd(8'h00, -1, 0, 4'h0);
    cmd(8'h11, -1, 0, 4'h0);
    cmd(8'h60, -1, 0, 4'h0);
    cmd(8'h71, -1, 0, 4'h0);
  endtask

  task automatic t_reads();
    for (int m = 0; m < 2; m++) begin
      bus16 <= m[0];
      rd1(8'h53, stv(3), 1);
      rd1(8'h50, stv(0), 1);
      rd1(8'hD5, stv(5), 0);
      rd1(8'hDF, stv(15), 0);
      rd1(8'hA2, ~stv(2), 0);
      rd1(8'hA1, ~stv(1), 0);
    end
    host.wr(1'b1, 16'h00B4);
    rdw(16'h05A3);
    host.wr(1'b1, 16'h00C0);
    rdw(16'hE1F0);
    rdw(16'hC3D2);
    bus16 <= 1'b0;
    host.wr(1'b1, 16'h00B4);
    rdw(16'h00A3);
    rdw(16'h0005);
    host.wr(1'b1, 16'h00C0);
    for (int k = 0; k < 4; k++) rdw({8'h00, intr_reg[8*k +: 8]});
  endtask

  task automatic t_scratch_unlock();
    int s6;
    host.wr(1'b1, 16'h00B2);
    host.wr(1'b0, 16'h0034);
    host.wr(1'b0, 16'h0012);
    chk(scr, 16'h1234);
    host.wr(1'b1, 16'h00B3);
    rdw(16'h0034);
    rdw(16'h0012);
    s6 = cnt[6];
    host.wr(1'b1, 16'h00B0);
    host.wr(1'b0, 16'h0037);
    host.wr(1'b0, 16'h00AB);
    chk(unl, 1'b0);
    chk(cnt[6] - s6, 0);
    host.wr(1'b1, 16'h00B0);
    host.wr(1'b0, 16'h0037);
    host.wr(1'b0, 16'h00AA);
    chk(unl, 1'b1);
    chk(cnt[6] - s6, 1);
    @(posedge clock) lock_req <= 1'b1;
    @(posedge clock) lock_req <= 1'b0;
    @(posedge clock);
    chk(unl, 1'b0);
    bus16 <= 1'b1;
    host.wr(1'b1, 16'h00B0);
    host.wr(1'b0, 16'hAA37);
    chk(unl, 1'b1);
    host.wr(1'b1, 16'h00B2);
    host.wr(1'b0, 16'hABCD);
    host.wr(1'b1, 16'h00B3);
    rdw(16'hABCD);
  endtask

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task automatic results();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Watchdog at 20000 cycles, well beyond the thousand or so cycles the scenarios need.
  initial begin
    #(20000 * 50);
    fail_count++;
    results();
  end

  initial begin
    for (int k = 0; k < 8; k++) cnt[k] = 0;
    for (int k = 0; k < 16; k++) ep_status[8*k +: 8] = stv(k);
    ep_err_code = ~ep_status;
    frame_num   = 11'h5A3;
    intr_reg    = 32'hC3D2_E1F0;
    bus16       = 1'b0;
    lock_req    = 1'b0;
    rst_b       = 1'b0;
    fail_count  = 0;
    checks      = 0;
    oe_cnt      = 0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    chk({unl, scr, ep}, 21'h0);
    t_nodata();
    t_reads();
    t_scratch_unlock();
    results();
  end
endmodule

`default_nettype wire
